// [pkg/wdt_pkg.sv]
// Shared constants for the watchdog with shared scaler
package wdt_pkg;

  // Register bus geometry
  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;
  localparam int CFG_W  = 14;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_OPTION = 14'h0081;
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 14'h2007;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 14'h0090;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 14'h0091;

  // Option register fields and reset value
  localparam logic [DATA_W-1:0] OPTION_RST = 8'hFF;
  localparam int BIT_ASSIGN  = 3;
  localparam int RATIO_LSB   = 0;
  localparam int RATIO_W     = 3;

  // Configuration word field
  localparam int CFG_ENABLE_BIT = 2;

  // Event status layout
  localparam int EV_W     = 3;
  localparam int EV_RESET = 0;
  localparam int EV_WAKE  = 1;
  localparam int EV_BASE  = 2;

  // Scaler helpers
  localparam int SCALE_W = 8;
  localparam logic [SCALE_W-1:0] SCALE_ONE = 8'h01;
  localparam logic [SCALE_W-1:0] SCALE_TWO = 8'h02;
  localparam logic [SCALE_W-1:0] SCALE_ZERO = 8'h00;

  // Read value of unmapped or idle read data
  localparam logic [DATA_W-1:0] RD_IDLE = 8'h00;

  // Power state of the core
  typedef enum logic [0:0] {
    WDT_RUN,
    WDT_SLEEP
  } wdt_pwr_e;

endpackage

// [core/wdt_core.sv]
// Watchdog timer with shared Timer0/watchdog scaler and register port
//
// Local design decision: the plain strobed port.

// Summary of operation
// - Base count advances only on ticks of the dedicated free-running RC oscillator.
// - Expiry during normal execution requests a full device watchdog reset.
// - Expiry during sleep wakes the core, which continues instead of resetting.
// - Every expiry clears the time-out status flag.
// - Enable fuse at zero keeps the watchdog permanently stopped.
// - One scaler serves Timer0 or the watchdog, chosen by option register.
// - Clear or sleep instruction zeroes base count, and scaler when assigned.
// - Clear instruction zeroes scaler count only while assigned to the watchdog, and keeps the assignment bit.
module wdt_core #(
  parameter int BASE_TICKS = 1024
) (
  // Clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  // Register port
  input  wire logic [wdt_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [wdt_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [wdt_pkg::DATA_W-1:0]   reg_rdata,
  // Fuses and oscillator
  input  wire logic [wdt_pkg::CFG_W-1:0]    config_word,
  input  wire logic                         rc_osc_tick,
  // Instruction events from the core
  input  wire logic                         watchdog_clear_instruction,
  input  wire logic                         sleep_instruction,
  // Timer0 side of the shared scaler
  input  wire logic                         tmr0_src_edge,
  output logic                              tmr0_count_tick,
  // Device control
  output logic                              watchdog_reset_req,
  output logic                              wake_req,
  output logic                              core_sleeping,
  output logic                              timeout_status_flag,
  // Interrupt
  output logic                              irq
);

  // Base counter width; one spare code so any period fits
  localparam int BASE_W = $clog2(BASE_TICKS + 1);
  localparam logic [BASE_W-1:0] BASE_LAST = BASE_W'(BASE_TICKS - 1);
  localparam logic [BASE_W-1:0] BASE_ZERO = '0;

  // State
  logic [wdt_pkg::CFG_W-1:0]   cfg_r;
  logic                        cfg_loaded_r;
  logic [wdt_pkg::DATA_W-1:0]  option_r;
  logic [BASE_W-1:0]           base_r;
  logic [wdt_pkg::SCALE_W-1:0] scale_r;
  logic [wdt_pkg::EV_W-1:0]    status_r;
  logic [wdt_pkg::EV_W-1:0]    mask_r;
  logic [wdt_pkg::DATA_W-1:0]  rdata_r;
  logic                        to_flag_r;
  logic                        reset_req_r;
  logic                        wake_r;
  logic                        tmr0_tick_r;
  wdt_pkg::wdt_pwr_e           pwr_r;

  // Next values
  logic [wdt_pkg::DATA_W-1:0]  option_nxt;
  logic [BASE_W-1:0]           base_nxt;
  logic [wdt_pkg::SCALE_W-1:0] scale_nxt;
  logic [wdt_pkg::DATA_W-1:0]  rdata_nxt;
  logic                        to_flag_nxt;
  wdt_pkg::wdt_pwr_e           pwr_nxt;

  // Decoded controls
  logic                        wdt_enabled;
  logic                        wdt_assigned;
  logic [wdt_pkg::RATIO_W-1:0] ratio_sel;
  logic [wdt_pkg::SCALE_W-1:0] scale_lim;
  logic                        restart;
  logic                        base_exp;
  logic                        scale_step;
  logic                        scale_hit;
  logic                        expiry;
  logic                        wr_option;
  logic                        wr_status;
  logic                        wr_mask;
  logic [wdt_pkg::EV_W-1:0]    ev_set;

  // Fuse and option decode
  // An empty fuse word before the first capture keeps the counter still
  assign wdt_enabled  = cfg_loaded_r & cfg_r[wdt_pkg::CFG_ENABLE_BIT];
  assign wdt_assigned = option_r[wdt_pkg::BIT_ASSIGN];
  assign ratio_sel    = option_r[wdt_pkg::RATIO_LSB +: wdt_pkg::RATIO_W];

  // Instructions restart the count so no time-out is pending
  assign restart = watchdog_clear_instruction | sleep_instruction;

  // Base period ends on the last oscillator tick
  // A restart in the same cycle cancels the expiry, so no late time-out
  assign base_exp = wdt_enabled & rc_osc_tick & (base_r == BASE_LAST) & ~restart;

  // Scaler limit: 2^n - 1 for watchdog, 2^(n+1) - 1 for Timer0
  // Timer0 side needs one step more, so its smallest ratio is 1:2
  always_comb begin
    if (wdt_assigned) begin
      scale_lim = (wdt_pkg::SCALE_ONE << ratio_sel) - wdt_pkg::SCALE_ONE;
    end else begin
      scale_lim = (wdt_pkg::SCALE_TWO << ratio_sel) - wdt_pkg::SCALE_ONE;
    end
  end

  // Scaler input follows its current owner
  // A change of owner keeps the count; software clears it first
  assign scale_step = wdt_assigned ? base_exp : tmr0_src_edge;
  assign scale_hit  = scale_step & (scale_r == scale_lim);

  // Watchdog time-out after the postscaler
  // Owner bit decides whether the postscaler sits in the time-out path
  assign expiry = wdt_assigned ? scale_hit : base_exp;

  // Register strobes
  // Unmapped addresses decode to nothing, so writes there are dropped
  assign wr_option = reg_wr & (reg_addr == wdt_pkg::OFS_OPTION);
  assign wr_status = reg_wr & (reg_addr == wdt_pkg::OFS_STATUS);
  assign wr_mask   = reg_wr & (reg_addr == wdt_pkg::OFS_MASK);

  // Events that latch into the status register
  // Base expiries are logged too, so software can watch postscaler progress
  always_comb begin
    ev_set = '0;
    ev_set[wdt_pkg::EV_RESET] = expiry & (pwr_r == wdt_pkg::WDT_RUN);
    ev_set[wdt_pkg::EV_WAKE]  = expiry & (pwr_r == wdt_pkg::WDT_SLEEP);
    ev_set[wdt_pkg::EV_BASE]  = base_exp;
  end

  // Fuse word caught once after reset release
  // Limitation: a fuse change takes effect only after the next reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_r        <= '0;
      cfg_loaded_r <= 1'b0;
    end else if (!cfg_loaded_r) begin
      cfg_r        <= config_word;
      cfg_loaded_r <= 1'b1;
    end
  end

  // Base counter next value; a restart or a blank fuse holds it at zero
  always_comb begin
    base_nxt = base_r;
    if (!wdt_enabled || restart) begin
      base_nxt = BASE_ZERO;
    end else if (rc_osc_tick) begin
      if (base_r == BASE_LAST) begin
        base_nxt = BASE_ZERO;
      end else begin
        base_nxt = base_r + BASE_W'(1);
      end
    end
  end

  // Base counter; clocked by core_clk and moved only on sampled oscillator ticks, so it stops when the core clock stops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      base_r <= BASE_ZERO;
    end else begin
      base_r <= base_nxt;
    end
  end

  // Shared scaler next value
  // Clear only touches the count, never the owner bit
  always_comb begin
    scale_nxt = scale_r;
    if (restart && wdt_assigned) begin
      scale_nxt = wdt_pkg::SCALE_ZERO;
    end else if (expiry && (pwr_r == wdt_pkg::WDT_RUN)) begin
      scale_nxt = wdt_pkg::SCALE_ZERO;
    end else if (scale_hit) begin
      scale_nxt = wdt_pkg::SCALE_ZERO;
    end else if (scale_step) begin
      scale_nxt = scale_r + wdt_pkg::SCALE_ONE;
    end
  end

  // Shared scaler register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scale_r <= wdt_pkg::SCALE_ZERO;
    end else begin
      scale_r <= scale_nxt;
    end
  end

  // Timer0 gets one tick per full prescale cycle
  // Registered so the tick never glitches with the scaler compare
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tmr0_tick_r <= 1'b0;
    end else begin
      tmr0_tick_r <= scale_hit & ~wdt_assigned;
    end
  end

  // Option next value; a watchdog reset restores it, as any device reset would
  always_comb begin
    option_nxt = option_r;
    if (ev_set[wdt_pkg::EV_RESET]) begin
      option_nxt = wdt_pkg::OPTION_RST;
    end else if (wr_option) begin
      option_nxt = reg_wdata;
    end
  end

  // Option register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      option_r <= wdt_pkg::OPTION_RST;
    end else begin
      option_r <= option_nxt;
    end
  end

  // Power state next value; sleep and wake
  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      wdt_pkg::WDT_RUN: begin
        if (sleep_instruction && !expiry) begin
          pwr_nxt = wdt_pkg::WDT_SLEEP;
        end
      end
      wdt_pkg::WDT_SLEEP: begin
        if (expiry) begin
          pwr_nxt = wdt_pkg::WDT_RUN;
        end
      end
      default: begin
        pwr_nxt = wdt_pkg::WDT_RUN;
      end
    endcase
  end

  // Power state register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pwr_r <= wdt_pkg::WDT_RUN;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  // Reset request, one cycle per expiry while running
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reset_req_r <= 1'b0;
    end else begin
      reset_req_r <= ev_set[wdt_pkg::EV_RESET];
    end
  end

  // Wake request, one cycle per expiry while asleep
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= ev_set[wdt_pkg::EV_WAKE];
    end
  end

  // Time-out flag next value: restart sets it, expiry clears it
  // Restart blocks expiry in the same cycle, so set wins
  always_comb begin
    to_flag_nxt = to_flag_r;
    if (restart) begin
      to_flag_nxt = 1'b1;
    end else if (expiry) begin
      to_flag_nxt = 1'b0;
    end
  end

  // Time-out flag register; power-on sets it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      to_flag_r <= 1'b1;
    end else begin
      to_flag_r <= to_flag_nxt;
    end
  end

  // Sticky events, one flop per bit; write one to clear
  // A new event wins, so an expiry landing on the clear write is never lost
  for (genvar ev = 0; ev < wdt_pkg::EV_W; ev++) begin : g_status
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        status_r[ev] <= 1'b0;
      end else if (ev_set[ev]) begin
        status_r[ev] <= 1'b1;
      end else if (wr_status && reg_wdata[ev]) begin
        status_r[ev] <= 1'b0;
      end
    end
  end

  // Interrupt mask
  // Mask gates only the interrupt, never the status bits
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mask_r <= '0;
    end else if (wr_mask) begin
      mask_r <= reg_wdata[wdt_pkg::EV_W-1:0];
    end
  end

  // Read mux; outside the answer cycle the port shows the idle value
  always_comb begin
    rdata_nxt = wdt_pkg::RD_IDLE;
    if (reg_rd) begin
      case (reg_addr)
        wdt_pkg::OFS_OPTION: rdata_nxt = option_r;
        wdt_pkg::OFS_CONFIG: rdata_nxt = cfg_r[wdt_pkg::DATA_W-1:0];
        wdt_pkg::OFS_STATUS: rdata_nxt = {{(wdt_pkg::DATA_W-wdt_pkg::EV_W){1'b0}}, status_r};
        wdt_pkg::OFS_MASK:   rdata_nxt = {{(wdt_pkg::DATA_W-wdt_pkg::EV_W){1'b0}}, mask_r};
        default:             rdata_nxt = wdt_pkg::RD_IDLE;
      endcase
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= wdt_pkg::RD_IDLE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs
  // Sleep indication is decoded straight from the state flop
  assign reg_rdata           = rdata_r;
  assign tmr0_count_tick     = tmr0_tick_r;
  assign watchdog_reset_req  = reset_req_r;
  assign wake_req            = wake_r;
  assign core_sleeping       = (pwr_r == wdt_pkg::WDT_SLEEP);
  assign timeout_status_flag = to_flag_r;
  assign irq                 = |(status_r & mask_r); // Level while any unmasked event stands

endmodule

// [testbench/wdt_checker.sv]
// Port checker for the watchdog core
module wdt_checker #(
  parameter int BASE_TICKS = 1024
) (
  // Clock, reset and events
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rc_osc_tick,
  input wire logic watchdog_clear_instruction,
  input wire logic sleep_instruction,
  // Device control
  input wire logic watchdog_reset_req,
  input wire logic wake_req,
  input wire logic core_sleeping,
  input wire logic timeout_status_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  // One domain, so one clock and one reset for all
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Expiry outcomes
  property p_rst_flag; watchdog_reset_req |-> !timeout_status_flag; endproperty
  a_rst_flag: assert property (p_rst_flag) else $error("reset request with flag set");
  property p_wake; wake_req |-> $past(core_sleeping) && !core_sleeping; endproperty
  a_wake: assert property (p_wake) else $error("wake without sleep exit");
  property p_awake_rst; watchdog_reset_req |-> !$past(core_sleeping); endproperty
  a_awake_rst: assert property (p_awake_rst) else $error("reset request while asleep");
  property p_rst_pulse; watchdog_reset_req |=> !watchdog_reset_req; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset request too long");
  // Restart instructions
  property p_clr_flag; watchdog_clear_instruction |=> timeout_status_flag; endproperty
  a_clr_flag: assert property (p_clr_flag) else $error("flag low after clear");
  property p_sleep; sleep_instruction |=> core_sleeping && timeout_status_flag; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
  property p_clr_cancel; watchdog_clear_instruction |=> !(watchdog_reset_req || wake_req); endproperty
  a_clr_cancel: assert property (p_clr_cancel) else $error("expiry after clear");
  // Counting only on oscillator ticks; the flag only falls on expiry
  property p_tick_only; !rc_osc_tick |=> !(watchdog_reset_req || wake_req); endproperty
  a_tick_only: assert property (p_tick_only) else $error("expiry without tick");
  property p_flag_fell; $fell(timeout_status_flag) |-> watchdog_reset_req || wake_req; endproperty
  a_flag_fell: assert property (p_flag_fell) else $error("flag fell without expiry");
endmodule

bind wdt_core wdt_checker #(.BASE_TICKS(BASE_TICKS)) u_wdt_checker (
  .core_clk(core_clk), .rst(rst), .rc_osc_tick(rc_osc_tick), .sleep_instruction(sleep_instruction),
  .watchdog_clear_instruction(watchdog_clear_instruction), .watchdog_reset_req(watchdog_reset_req),
  .wake_req(wake_req), .core_sleeping(core_sleeping), .timeout_status_flag(timeout_status_flag));

// [testbench/testbench.sv]
// Self-checking bench for the watchdog core
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk, rst, reg_wr, reg_rd, t0_tick, rst_req, wake_req, sleeping, flag, irq;
  logic [13:0] reg_addr, config_word;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [3:0]  pul;
  logic [31:0] seed = 32'h8a4e_2d97;
  logic [7:0]  opt_tab [4] = '{8'h00, 8'h08, 8'h09, 8'h0b};
  int          fails, total_checks, n_req, n_t0, cyc, n, base;

  // Short base period keeps each expiry within a few hundred cycles
  localparam int MODEL_BASE = 4;
  wdt_core #(.BASE_TICKS(MODEL_BASE)) u_wdt_core (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .config_word(config_word),
    .rc_osc_tick(pul[0]), .watchdog_clear_instruction(pul[1]), .sleep_instruction(pul[2]),
    .tmr0_src_edge(pul[3]), .tmr0_count_tick(t0_tick), .watchdog_reset_req(rst_req), .wake_req(wake_req),
    .core_sleeping(sleeping), .timeout_status_flag(flag), .irq(irq));

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Event counters and hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    n_req <= n_req + rst_req + wake_req;
    n_t0 <= n_t0 + t0_tick;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Model: base ticks to a time-out, times the postscale ratio when assigned
  function automatic int m_period(input logic [7:0] opt);
    return opt[3] ? (MODEL_BASE << opt[2:0]) : MODEL_BASE;
  endfunction

  // Model: Timer0 ticks for a number of source edges at a given ratio
  function automatic int m_t0(input int r, input int edges);
    return edges >> (r + 1);
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t: saw %h want %h", $time, got, exp);
    end
  endtask

  // Register cycles; the trailing edge keeps strobes from being driven twice in one step
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [13:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
    @(posedge core_clk);
  endtask

  // One-cycle event pulse, then a gap
  task automatic pulse(input int b, input int g);
    pul[b] <= 1'b1;
    @(posedge core_clk);
    pul[b] <= 1'b0;
    repeat (g) @(posedge core_clk);
  endtask

  // Oscillator ticks at random spacing until a request shows
  task automatic expire();
    n = 0;
    base = n_req;
    while (n_req == base && n < 600) begin
      pulse(0, 3 + rnd() % 3);
      n++;
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    pul = 4'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 14'h0000;
    reg_wdata = 8'h00;
    config_word = 14'h3fff;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd(wdt_pkg::OFS_OPTION, 8'hff);
    rd(wdt_pkg::OFS_CONFIG, 8'hff);
    rd(14'h0000, 8'h00);
    chk({7'h00, flag}, 8'h01);
    wr(wdt_pkg::OFS_MASK, 8'h07);
    $display("test reset done");
    // Four postscale cases: base, then ratios 1, 2 and 8
    for (int i = 0; i < 4; i++) begin
      wr(wdt_pkg::OFS_OPTION, opt_tab[i]);
      pulse(1, 1);
      expire();
      chk(8'(n), 8'(m_period(opt_tab[i])));
      chk({6'h00, irq, flag}, 8'h02);
      rd(wdt_pkg::OFS_STATUS, 8'h05);
      rd(wdt_pkg::OFS_OPTION, 8'hff);
      wr(wdt_pkg::OFS_STATUS, 8'h07);
      pulse(1, 1);
      chk({6'h00, irq, flag}, 8'h01);
    end
    $display("test expiry done");
    // Clear late in the count must restart both counts
    wr(wdt_pkg::OFS_OPTION, 8'h09);
    repeat (6) pulse(0, 3);
    pulse(1, 1);
    rd(wdt_pkg::OFS_OPTION, 8'h09);
    expire();
    chk(8'(n), 8'(m_period(8'h09)));
    wr(wdt_pkg::OFS_STATUS, 8'h07);
    $display("test restart done");
    wr(wdt_pkg::OFS_OPTION, 8'h00);
    pulse(2, 1);
    chk({7'h00, sleeping}, 8'h01);
    expire();
    chk(8'(n), 8'(m_period(8'h00)));
    chk({6'h00, sleeping, flag}, 8'h00);
    rd(wdt_pkg::OFS_STATUS, 8'h06);
    rd(wdt_pkg::OFS_OPTION, 8'h00);
    $display("test sleep done");
    // Scaler on Timer0; zeroed first through the watchdog side
    for (int r = 0; r < 3; r++) begin
      wr(wdt_pkg::OFS_OPTION, 8'h08);
      pulse(1, 1);
      wr(wdt_pkg::OFS_OPTION, 8'(r));
      base = n_t0;
      repeat (16) pulse(3, 1);
      repeat (3) @(posedge core_clk);
      chk(8'(n_t0 - base), 8'(m_t0(r, 16)));
    end
    $display("test timer0 done");
    config_word <= 14'h3ffb;
    rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd(wdt_pkg::OFS_CONFIG, 8'hfb);
    wr(wdt_pkg::OFS_OPTION, 8'h00);
    base = n_req;
    repeat (12) pulse(0, 3);
    chk(8'(n_req - base), 8'h00);
    $display("test fuse done");
    close_out();
  end
endmodule
